// ### hw/ccdr_timing_gen.sv
// Timing generator end: mode sequencing, sweeps and line buffering
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_map.svh"

module ccdr_timing_gen #(
  parameter int FRAME_CYC_FPS9 = `CCDR_T_FPS9_NS / `CCDR_CLK_NS,
  parameter int FRAME_CYC_FPS15 = `CCDR_T_FPS15_NS / `CCDR_CLK_NS,
  parameter int FRAME_CYC_FPS20 = `CCDR_T_FPS20_NS / `CCDR_CLK_NS,
  parameter int FRAME_CYC_FPS30 = `CCDR_T_FPS30_NS / `CCDR_CLK_NS,
  parameter int FRAME_CYC_FPS60 = `CCDR_T_FPS60_NS / `CCDR_CLK_NS,
  parameter int FRAME_CYC_FPS120 = `CCDR_T_FPS120_NS / `CCDR_CLK_NS
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire ccdr_pkg::ccdr_mode_type MODE_I,
  input wire logic RATE36_I,
  input wire logic LINE_READY_I,
  output logic LINE_VALID_O,
  output ccdr_pkg::ccdr_line_type LINE_O,
  output logic FRAME_O,
  output ccdr_pkg::ccdr_mode_type ACTIVE_MODE_O,
  ccdr_if.tg LINK
);
  import ccdr_pkg::*;

  ccdr_state_type state_reg;
  logic rate36_reg;
  logic [31:0] timer_reg;
  logic [`CCDR_LINE_W-1:0] step_reg;
  logic [`CCDR_LINE_W-1:0] top_reg;
  logic [`CCDR_LINE_W-1:0] end_reg;
  logic frame_reg;
  logic [2:0] gate_reg;
  logic vshift_reg;
  logic sweep_reg;
  logic can_shift;
  logic [`CCDR_LINE_W-1:0] region;
  logic skid_valid_reg;
  logic skid_valid_next;
  ccdr_line_type skid_reg;
  logic room_reg;
  logic accept;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Mode tables, nine schemes

  // Log2 of sensor lines consumed per output line
  function automatic logic [1:0] lines_shift(input ccdr_mode_type m);
    logic [1:0] s;
    unique case (m)
      CCDR_PROG, CCDR_CUT3: s = 2'h0;
      CCDR_DEC28, CCDR_AF1, CCDR_AF2: s = 2'h2;
      CCDR_DEC24, CCDR_ADD2, CCDR_CUT1, CCDR_CUT2: s = 2'h1;
      default: s = 2'h0;
    endcase
    return s;
  endfunction

  function automatic logic is_add(input ccdr_mode_type m);
    return (m == CCDR_ADD2) || (m == CCDR_CUT2);
  endfunction

  // Group pulsed first in each mode
  function automatic logic [2:0] first_mask(input ccdr_mode_type m);
    logic [2:0] g;
    unique case (m)
      CCDR_PROG, CCDR_CUT3: g = `CCDR_GRP_ALL;
      CCDR_DEC28, CCDR_AF1, CCDR_AF2: g = `CCDR_GRP_A;
      CCDR_DEC24, CCDR_CUT1: g = `CCDR_GRP_C;
      CCDR_ADD2, CCDR_CUT2: g = `CCDR_GRP_C;
      default: g = `CCDR_GRP_ALL;
    endcase
    return g;
  endfunction

  // Output lines per frame; full modes cover every sensor line
  function automatic logic [`CCDR_LINE_W-1:0] out_lines(input ccdr_mode_type m,
                                                        input logic r36);
    logic [`CCDR_LINE_W-1:0] n;
    unique case (m)
      CCDR_CUT1, CCDR_CUT2: n = r36 ? `CCDR_CUT1_OUT36 : `CCDR_CUT1_OUT28;
      CCDR_CUT3: n = r36 ? `CCDR_CUT3_OUT36 : `CCDR_CUT3_OUT28;
      CCDR_AF1: n = r36 ? `CCDR_AF1_OUT36 : `CCDR_AF1_OUT28;
      CCDR_AF2: n = r36 ? `CCDR_AF2_OUT36 : `CCDR_AF2_OUT28;
      default: n = `CCDR_TOTAL_LINES >> lines_shift(m);
    endcase
    return n;
  endfunction

  // Frame period in clock cycles
  function automatic logic [31:0] period(input ccdr_mode_type m, input logic r36);
    int p;
    unique case (m)
      CCDR_PROG: p = r36 ? FRAME_CYC_FPS15 : FRAME_CYC_FPS9;
      CCDR_DEC28: p = FRAME_CYC_FPS30;
      CCDR_DEC24, CCDR_ADD2: p = FRAME_CYC_FPS20;
      CCDR_CUT1, CCDR_CUT2, CCDR_CUT3: p = FRAME_CYC_FPS30;
      CCDR_AF1: p = FRAME_CYC_FPS60;
      CCDR_AF2: p = FRAME_CYC_FPS120;
      default: p = FRAME_CYC_FPS15;
    endcase
    return 32'(p);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  assign region = out_lines(ACTIVE_MODE_O, rate36_reg) << lines_shift(ACTIVE_MODE_O);
  // One shift at a time, and only once the previous word has gone
  assign can_shift = !vshift_reg && !LINK.line_valid;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg <= CCDR_S_START;
      ACTIVE_MODE_O <= CCDR_PROG;
      rate36_reg <= 1'b0;
      timer_reg <= 32'h0000_0000;
      step_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 32'h0000_0001;
      unique case (state_reg)
        CCDR_S_START: begin
          // Mode and rate are sampled only here
          ACTIVE_MODE_O <= MODE_I;
          rate36_reg <= RATE36_I;
          timer_reg <= 32'h0000_0000;
          step_reg <= '0;
          state_reg <= CCDR_S_GATE1;
        end
        CCDR_S_GATE1: begin
          state_reg <= is_add(ACTIVE_MODE_O) ? CCDR_S_PRE : CCDR_S_SHIFT;
        end
        CCDR_S_PRE: begin
          if (can_shift) begin
            step_reg <= step_reg + 11'h001;
            if (step_reg == `CCDR_ADD_SHIFT - 11'h001) begin
              state_reg <= CCDR_S_GATE2;
            end
          end
        end
        CCDR_S_GATE2: begin
          state_reg <= CCDR_S_SHIFT;
        end
        CCDR_S_SHIFT: begin
          if (can_shift) begin
            step_reg <= step_reg + 11'h001;
            if (step_reg == `CCDR_TOTAL_LINES + `CCDR_ADD_SHIFT - 11'h001) begin
              state_reg <= CCDR_S_WAIT;
            end
          end
        end
        CCDR_S_WAIT: begin
          if (timer_reg >= period(ACTIVE_MODE_O, rate36_reg) - 32'h0000_0001) begin
            state_reg <= CCDR_S_START;
          end
        end
      endcase
    end
  end

  // Sweep window limits, fixed once the mode is latched
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      top_reg <= '0;
      end_reg <= '0;
    end else if (state_reg == CCDR_S_GATE1) begin
      top_reg <= (`CCDR_TOTAL_LINES - region) >> 1;
      end_reg <= ((`CCDR_TOTAL_LINES - region) >> 1) + region
                 + (is_add(ACTIVE_MODE_O) ? `CCDR_ADD_SHIFT : 11'h000);
    end
  end

  // Link strobes
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      frame_reg <= 1'b0;
      gate_reg <= 3'h0;
      vshift_reg <= 1'b0;
      sweep_reg <= 1'b0;
    end else begin
      frame_reg <= (state_reg == CCDR_S_START);
      gate_reg <= 3'h0;
      if (state_reg == CCDR_S_GATE1) begin
        gate_reg <= first_mask(ACTIVE_MODE_O);
      end else if (state_reg == CCDR_S_GATE2) begin
        gate_reg <= `CCDR_GRP_A | `CCDR_GRP_B;
      end
      vshift_reg <= can_shift && (state_reg == CCDR_S_PRE || state_reg == CCDR_S_SHIFT);
      // Lines outside the kept window leave by high-speed transfer
      sweep_reg <= (state_reg == CCDR_S_SHIFT) && ((step_reg < top_reg) || (step_reg >= end_reg));
    end
  end

  assign LINK.frame_start = frame_reg;
  assign LINK.mode = ACTIVE_MODE_O;
  assign LINK.readout_gate = gate_reg;
  assign LINK.vshift = vshift_reg;
  assign LINK.sweep = sweep_reg;
  assign LINK.line_ready = room_reg;
  assign FRAME_O = frame_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry line buffer: output stage plus skid stage

  assign accept = LINK.line_valid && room_reg;
  assign pop = LINE_VALID_O && LINE_READY_I;

  always_comb begin
    skid_valid_next = skid_valid_reg;
    if (pop || !LINE_VALID_O) begin
      skid_valid_next = skid_valid_reg && accept;
    end else if (accept) begin
      skid_valid_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      LINE_VALID_O <= 1'b0;
      LINE_O <= '0;
      skid_valid_reg <= 1'b0;
      skid_reg <= '0;
      room_reg <= 1'b1;
    end else begin
      skid_valid_reg <= skid_valid_next;
      room_reg <= !skid_valid_next;
      if (pop || !LINE_VALID_O) begin
        if (skid_valid_reg) begin
          LINE_VALID_O <= 1'b1;
          LINE_O <= skid_reg;
          if (accept) begin
            skid_reg <= LINK.line;
          end
        end else begin
          LINE_VALID_O <= accept;
          if (accept) begin
            LINE_O <= LINK.line;
          end
        end
      end else if (accept) begin
        skid_reg <= LINK.line;
      end
    end
  end

endmodule

`default_nettype wire

// ### inc/ccdr_map.svh
// Constants of the sensor readout sequencer link
`ifndef CCDR_MAP_SVH
`define CCDR_MAP_SVH

`define CCDR_CLK_NS 5
`define CCDR_LINE_W 11
`define CCDR_TOTAL_LINES 11'h4e0
`define CCDR_ADD_SHIFT 11'h002
`define CCDR_GRP_A 3'h1
`define CCDR_GRP_B 3'h2
`define CCDR_GRP_C 3'h4
`define CCDR_GRP_ALL 3'h7

// Frame periods in ns, one per documented frame rate
`define CCDR_T_FPS9_NS 100100100
`define CCDR_T_FPS15_NS 66733400
`define CCDR_T_FPS20_NS 50050050
`define CCDR_T_FPS30_NS 33366700
`define CCDR_T_FPS60_NS 16683350
`define CCDR_T_FPS120_NS 8341675

// Output line counts of the cut and AF modes at the fast and slow horizontal rate
`define CCDR_CUT1_OUT36 11'h238
`define CCDR_CUT1_OUT28 11'h1b2
`define CCDR_CUT3_OUT36 11'h244
`define CCDR_CUT3_OUT28 11'h1bc
`define CCDR_AF1_OUT36 11'h0eb
`define CCDR_AF1_OUT28 11'h0aa
`define CCDR_AF2_OUT36 11'h04b
`define CCDR_AF2_OUT28 11'h02b

`endif

// ### inc/ccdr_pkg.sv
// Types shared by the sensor end and the timing generator end
`include "ccdr_map.svh"

package ccdr_pkg;

  typedef enum logic [3:0] {
    CCDR_PROG, CCDR_DEC28, CCDR_DEC24, CCDR_ADD2,
    CCDR_CUT1, CCDR_CUT2, CCDR_CUT3, CCDR_AF1, CCDR_AF2
  } ccdr_mode_type;

  typedef struct packed {
    logic [`CCDR_LINE_W-1:0] first_line;
    logic [`CCDR_LINE_W-1:0] second_line;
    logic [1:0] sum_count;
    logic green_on_red_line;
  } ccdr_line_type;

  typedef enum logic [2:0] {
    CCDR_S_START, CCDR_S_GATE1, CCDR_S_PRE, CCDR_S_GATE2, CCDR_S_SHIFT, CCDR_S_WAIT
  } ccdr_state_type;

endpackage

// ### inc/ccdr_if.sv
// Link between the timing generator and the sensor readout model
`timescale 1ns/1ps
`default_nettype none

interface ccdr_if;
  import ccdr_pkg::*;
  logic frame_start;
  ccdr_mode_type mode;
  logic [2:0] readout_gate;
  logic vshift;
  logic sweep;
  logic line_valid;
  ccdr_line_type line;
  logic line_ready;

  modport tg (
    output frame_start, mode, readout_gate, vshift, sweep, line_ready,
    input line_valid, line
  );
  modport sensor (
    input frame_start, mode, readout_gate, vshift, sweep, line_ready,
    output line_valid, line
  );
endinterface

`default_nettype wire

// ### hw/ccdr_sensor.sv
// Sensor end: vertical register charge model and line output
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_map.svh"

module ccdr_sensor (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  ccdr_if.sensor LINK,
  output ccdr_pkg::ccdr_mode_type ACTIVE_MODE_O,
  output logic [`CCDR_LINE_W-1:0] LINE_COUNT_O
);
  import ccdr_pkg::*;

  logic [`CCDR_LINE_W-1:0] step_reg;
  logic [`CCDR_LINE_W-1:0] off_reg [2];
  logic [2:0] mask_reg [2];
  logic [1:0] npulse_reg;
  logic valid_reg;
  ccdr_line_type word_reg;
  ccdr_line_type word_next;
  logic hit0;
  logic hit1;
  logic [`CCDR_LINE_W-1:0] idx0;
  logic [`CCDR_LINE_W-1:0] idx1;

  // Readout group of a zero-based line index
  function automatic logic [2:0] group_of(input logic [`CCDR_LINE_W-1:0] idx);
    logic [2:0] g;
    unique case (idx[2:0])
      3'h0, 3'h5: g = `CCDR_GRP_A;
      3'h1, 3'h4: g = `CCDR_GRP_B;
      default: g = `CCDR_GRP_C;
    endcase
    return g;
  endfunction

  // Charge from one readout pulse reaches the output at this step
  function automatic logic charge_at(input logic [`CCDR_LINE_W-1:0] s,
                                     input logic [`CCDR_LINE_W-1:0] off,
                                     input logic [2:0] mask, input logic used);
    logic [`CCDR_LINE_W-1:0] d;
    d = s - off;
    return used && (s >= off) && (d < `CCDR_TOTAL_LINES) && ((group_of(d) & mask) != 3'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line assembly

  always_comb begin
    idx0 = step_reg - off_reg[0];
    idx1 = step_reg - off_reg[1];
    hit0 = charge_at(step_reg, off_reg[0], mask_reg[0], npulse_reg != 2'h0);
    hit1 = charge_at(step_reg, off_reg[1], mask_reg[1], npulse_reg == 2'h2);
    word_next = '0;
    // Two charges in one cell are a same-colour sum
    word_next.first_line = (hit0 ? idx0 : idx1) + 11'h001;
    word_next.second_line = (hit0 && hit1) ? idx1 + 11'h001 : 11'h000;
    word_next.sum_count = {1'b0, hit0} + {1'b0, hit1};
    // Odd lines carry red, even lines carry blue
    word_next.green_on_red_line = word_next.first_line[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame and readout pulse bookkeeping

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ACTIVE_MODE_O <= CCDR_PROG;
      step_reg <= '0;
      npulse_reg <= 2'h0;
      off_reg[0] <= '0;
      off_reg[1] <= '0;
      mask_reg[0] <= 3'h0;
      mask_reg[1] <= 3'h0;
    end else if (LINK.frame_start) begin
      ACTIVE_MODE_O <= LINK.mode;
      step_reg <= '0;
      npulse_reg <= 2'h0;
    end else begin
      // A readout pulse moves every selected photosite at once
      if (LINK.readout_gate != 3'h0 && npulse_reg != 2'h2) begin
        off_reg[npulse_reg[0]] <= step_reg;
        mask_reg[npulse_reg[0]] <= LINK.readout_gate;
        npulse_reg <= npulse_reg + 2'h1;
      end
      if (LINK.vshift) begin
        step_reg <= step_reg + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output word, held until the generator takes it

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      valid_reg <= 1'b0;
      word_reg <= '0;
    end else if (LINK.vshift && (hit0 || hit1) && !LINK.sweep) begin
      // Empty and swept cells give no word; lines are numbered from one
      valid_reg <= 1'b1;
      word_reg <= word_next;
    end else if (valid_reg && LINK.line_ready) begin
      valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      LINE_COUNT_O <= '0;
    end else if (LINK.frame_start) begin
      LINE_COUNT_O <= '0;
    end else if (valid_reg && LINK.line_ready) begin
      LINE_COUNT_O <= LINE_COUNT_O + 11'h001;
    end
  end

  assign LINK.line_valid = valid_reg;
  assign LINK.line = word_reg;

endmodule

`default_nettype wire

// ### testbench/ccdr_link_properties.sv
// Concurrent checks on the link between the timing generator and the sensor
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_map.svh"

module ccdr_link_properties (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic frame_start,
  input wire ccdr_pkg::ccdr_mode_type mode,
  input wire logic [2:0] readout_gate,
  input wire logic vshift,
  input wire logic sweep,
  input wire logic line_valid,
  input wire ccdr_pkg::ccdr_line_type line,
  input wire logic line_ready
);
  import ccdr_pkg::*;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  ////////////////////////////////////////////////////////////////////////////
  // Vertical steps since frame start, saturating at three
  logic [1:0] vsh_cnt_reg;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      vsh_cnt_reg <= 2'h0;
    end else if (frame_start) begin
      vsh_cnt_reg <= 2'h0;
    end else if (vshift && vsh_cnt_reg != 2'h3) begin
      vsh_cnt_reg <= vsh_cnt_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_gate_c;
    readout_gate == `CCDR_GRP_C;
  endsequence

  sequence s_gate_ab;
    readout_gate == (`CCDR_GRP_A | `CCDR_GRP_B);
  endsequence

  a_prog_all_gates: assert property (frame_start && (mode == CCDR_PROG || mode == CCDR_CUT3)
    |=> readout_gate == `CCDR_GRP_ALL) else $error("progressive readout gate wrong");
  a_eight_group_a: assert property (frame_start && (mode == CCDR_DEC28 || mode == CCDR_AF1
    || mode == CCDR_AF2) |=> readout_gate == `CCDR_GRP_A) else $error("two-of-eight gate wrong");
  a_four_group_c: assert property (frame_start && (mode == CCDR_DEC24 || mode == CCDR_CUT1)
    |=> readout_gate == `CCDR_GRP_C) else $error("two-of-four gate wrong");
  a_add_order: assert property (frame_start && mode == CCDR_ADD2
    |=> s_gate_c ##[1:100] s_gate_ab) else $error("addition readout order wrong");
  a_add_shift_two: assert property (s_gate_ab |-> vsh_cnt_reg == 2'h2)
    else $error("addition shift count wrong");
  a_mode_at_frame: assert property ($changed(mode) |-> frame_start)
    else $error("mode changed inside a frame");
  a_word_hold: assert property (line_valid && !line_ready |=> line_valid && $stable(line))
    else $error("waiting word lost or changed");
  a_shift_spacing: assert property (vshift |-> !line_valid ##1 !vshift)
    else $error("vertical step too early");
  a_green_tag: assert property (line_valid |-> line.green_on_red_line == line.first_line[0])
    else $error("green channel tag wrong");
  a_sum_pair: assert property (line_valid && line.sum_count == 2'h2
    |-> line.second_line + `CCDR_ADD_SHIFT == line.first_line) else $error("summed pair wrong");
  a_word_cause: assert property ($rose(line_valid) |-> $past(vshift) && !$past(sweep))
    else $error("word without unswept step");
endmodule

`default_nettype wire

// ### testbench/ccdr_readout_mode_sequencer_test.sv
// Self-checking bench joining the sensor end and the timing generator end
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_map.svh"

module ccdr_readout_mode_sequencer_test;
  import ccdr_pkg::*;
  localparam int FRAME_CYC = 3000;
  logic clk = 1'b0;
  logic resetn;
  logic rate36;
  logic ready = 1'b0;
  logic line_valid;
  logic frame;
  ccdr_mode_type mode_sel;
  ccdr_mode_type tg_mode;
  ccdr_mode_type sn_mode;
  ccdr_line_type line_word;
  ccdr_line_type exp_q[$];
  int err_total = 0;
  int num_checks = 0;
  int seed = 8466;
  int stall_cnt = 0;
  int extra_cnt = 0;
  int cnt_tab[11];
  logic [`CCDR_LINE_W-1:0] line_cnt;
  ccdr_mode_type mode_tab[10] = '{CCDR_PROG, CCDR_DEC28, CCDR_CUT1, CCDR_AF1, CCDR_DEC24,
    CCDR_CUT1, CCDR_CUT3, CCDR_AF2, CCDR_ADD2, CCDR_CUT2};
  logic rate_tab[10] = '{1, 0, 0, 0, 0, 1, 1, 1, 1, 1};

  initial begin
    forever #(`CCDR_CLK_NS / 2.0) clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  ccdr_if u_ccdr_if ();
  ccdr_sensor u_ccdr_sensor (.CLK_I(clk), .RESETN_I(resetn), .LINK(u_ccdr_if.sensor),
    .ACTIVE_MODE_O(sn_mode), .LINE_COUNT_O(line_cnt));
  ccdr_timing_gen #(.FRAME_CYC_FPS9(FRAME_CYC), .FRAME_CYC_FPS15(FRAME_CYC),
    .FRAME_CYC_FPS20(FRAME_CYC), .FRAME_CYC_FPS30(FRAME_CYC), .FRAME_CYC_FPS60(FRAME_CYC),
    .FRAME_CYC_FPS120(FRAME_CYC)) u_ccdr_timing_gen (.CLK_I(clk), .RESETN_I(resetn),
    .MODE_I(mode_sel), .RATE36_I(rate36), .LINE_READY_I(ready), .LINE_VALID_O(line_valid),
    .LINE_O(line_word), .FRAME_O(frame), .ACTIVE_MODE_O(tg_mode), .LINK(u_ccdr_if.tg));
  ccdr_link_properties u_props (.CLK_I(clk), .RESETN_I(resetn),
    .frame_start(u_ccdr_if.frame_start), .mode(u_ccdr_if.mode),
    .readout_gate(u_ccdr_if.readout_gate), .vshift(u_ccdr_if.vshift), .sweep(u_ccdr_if.sweep),
    .line_valid(u_ccdr_if.line_valid), .line(u_ccdr_if.line), .line_ready(u_ccdr_if.line_ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_frame();
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (frame !== 1'b1 && i < 20000);
    if (frame !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask

  // Notes every word that a frame in mode m should hand over, in order
  task automatic push_exp(input ccdr_mode_type m, input logic r, input int slot);
    int region;
    int cls;
    int n;
    ccdr_line_type w;
    region = `CCDR_TOTAL_LINES;
    cls = 0;
    case (m)
      CCDR_DEC28: cls = 1;
      CCDR_DEC24: cls = 2;
      CCDR_ADD2: cls = 3;
      CCDR_CUT1: begin
        cls = 2;
        region = 2 * (r ? `CCDR_CUT1_OUT36 : `CCDR_CUT1_OUT28);
      end
      CCDR_CUT3: region = r ? `CCDR_CUT3_OUT36 : `CCDR_CUT3_OUT28;
      CCDR_AF1: begin
        cls = 1;
        region = 4 * (r ? `CCDR_AF1_OUT36 : `CCDR_AF1_OUT28);
      end
      CCDR_AF2: begin
        cls = 1;
        region = 4 * (r ? `CCDR_AF2_OUT36 : `CCDR_AF2_OUT28);
      end
      CCDR_CUT2: begin
        cls = 3;
        region = 2 * (r ? `CCDR_CUT1_OUT36 : `CCDR_CUT1_OUT28);
      end
      default: cls = 0;
    endcase
    for (n = (`CCDR_TOTAL_LINES - region) / 2 + 1; n <= (`CCDR_TOTAL_LINES + region) / 2; n++) begin
      if (cls == 0 || (cls == 1 && (n % 8 == 1 || n % 8 == 6))
          || (cls >= 2 && (n % 4 == 3 || n % 4 == 0))) begin
        w = '{first_line: 11'(n), second_line: (cls == 3) ? 11'(n - 2) : 11'h000,
          sum_count: (cls == 3) ? 2'h2 : 2'h1, green_on_red_line: 1'(n % 2)};
        exp_q.push_back(w);
        cnt_tab[slot]++;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Receiver stalls at random, or for a forced stretch
  always @(negedge clk) begin
    if (stall_cnt != 0) begin
      stall_cnt = stall_cnt - 1;
      ready <= 1'b0;
    end else begin
      ready <= ($random(seed) % 4) != 0;
    end
  end

  always @(posedge clk) begin
    if (resetn === 1'b1 && line_valid === 1'b1 && ready === 1'b1) begin
      if (exp_q.size() > 0) begin
        check("line word", 32'(line_word), 32'(exp_q.pop_front()));
      end else begin
        extra_cnt++;
      end
    end
  end

  initial begin
    int k;
    resetn = 1'b0;
    mode_sel = mode_tab[0];
    rate36 = rate_tab[0];
    push_exp(mode_tab[0], rate_tab[0], 1);
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    for (k = 1; k <= 10; k++) begin
      wait_frame();
      check("line count", 32'(line_cnt), 32'(cnt_tab[k-1]));
      if (k < 10) begin
        mode_sel = mode_tab[k];
        rate36 = rate_tab[k];
        push_exp(mode_tab[k], rate_tab[k], k + 1);
      end
      @(negedge clk);
      check("active modes", 32'({sn_mode, tg_mode}), 32'({mode_tab[k-1], mode_tab[k-1]}));
      if (k == 1) begin
        repeat (100) @(negedge clk);
        @(posedge clk);
        stall_cnt = 40;
        repeat (30) @(negedge clk);
        check("full buffer", 32'({u_ccdr_if.line_ready, line_valid}), 32'h0000_0001);
      end
    end
    wait_frame();
    check("line count", 32'(line_cnt), 32'(cnt_tab[10]));
    repeat (10) @(negedge clk);
    check("pending words", 32'(exp_q.size()), 32'h0000_0000);
    check("extra words", 32'(extra_cnt), 32'h0000_0000);
    end_sim();
  end
endmodule

`default_nettype wire
